/* shared/fcsd_map.vh */
// Purpose: constants for the flash command sequence host controller
// Assumes: byte-wide flash bus, 200 MHz mclk
// Notes: Notes on behaviour below
// Notes on behaviour
// - values hex, unspecified bits ignored
// - bad sequence needs reset command
// - host must exit command-set modes
// - password word: A0 then word address
// - host uses full two-cycle password sequence
// - password reads use full address
// - unlock needs complete password, any order
// - acceleration input high when setting lock bits
// - buffered write unlock, 25, count, pairs
// - buffer count is locations minus one
`ifndef FCSD_MAP_VH
`define FCSD_MAP_VH
`define FCSD_REG_CTRL    4'h0
`define FCSD_REG_ADDR    4'h1
`define FCSD_REG_DATA    4'h2
`define FCSD_REG_RDATA   4'h3
`define FCSD_REG_STATUS  4'h4
`define FCSD_CTRL_GO     0
`define FCSD_CTRL_RD     1
`define FCSD_CTRL_ACC    2
`define FCSD_CTRL_UNL    3
`define FCSD_CTRL_LAST   4
`define FCSD_UNL1_ADDR   12'haaa
`define FCSD_UNL1_DATA   8'haa
`define FCSD_UNL2_ADDR   12'h555
`define FCSD_UNL2_DATA   8'h55
`define FCSD_SETUP_NS    20
`define FCSD_PULSE_NS    40
`define FCSD_HOLD_NS     20
`define FCSD_CLK_PS      5000
`endif

/* logic/fcsd_host.v */
// Purpose: host controller issuing flash command cycles from wishbone
// Assumes: software composes command sequences; one bus cycle per go, three with unlock prefix
// Notes: optional two-cycle unlock prefix inserted by hardware
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`include "fcsd_map.vh"
module fcsd_host #(
  parameter AW = 22
) (
  input  wire          mclk,
  input  wire          arst_n,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [3:0]    wb_adr_i,
  input  wire [31:0]   wb_dat_i,
  input  wire [3:0]    wb_sel_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  output reg  [AW-1:0] fl_addr,
  output reg  [7:0]    fl_dq_o,
  output reg           fl_dq_oe,
  input  wire [7:0]    fl_dq_i,
  output reg           fl_ce_n,
  output reg           fl_we_n,
  output reg           fl_oe_n,
  output reg           fl_acc
);
  function [7:0] ns2cyc;
    input integer ns;
    integer c;
    begin
      c = (ns * 1000 + `FCSD_CLK_PS - 1) / `FCSD_CLK_PS;
      if (c < 1)
        c = 1;
      ns2cyc = c[7:0];
    end
  endfunction
  localparam [7:0] T_SU = ns2cyc(`FCSD_SETUP_NS);
  localparam [7:0] T_PW = ns2cyc(`FCSD_PULSE_NS);
  localparam [7:0] T_HD = ns2cyc(`FCSD_HOLD_NS);
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_SU   = 2'd1;
  localparam [1:0] S_PW   = 2'd2;
  localparam [1:0] S_HD   = 2'd3;
  reg [1:0]    st_q;
  reg [7:0]    cnt_q;
  reg [AW-1:0] addr_q;
  reg [7:0]    data_q;
  reg          rd_q;
  reg [1:0]    pre_q;
  reg          busy_q;
  reg [7:0]    rdata_q;
  reg [7:0]    dq_s1_q;
  reg [7:0]    dq_s2_q;
  reg [3:0]    ncyc_q;
  reg [7:0]    d_q;
  reg          acc_q;
  wire         wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire         wr_ok  = wb_req & wb_we_i & wb_sel_i[0];
  // current cycle's address and data, unlock prefix first
  wire [AW-1:0] cur_a = (pre_q == 2'd2) ? {{(AW-12){1'b0}}, `FCSD_UNL1_ADDR} :
                        (pre_q == 2'd1) ? {{(AW-12){1'b0}}, `FCSD_UNL2_ADDR} : addr_q;
  wire [7:0]    cur_d = (pre_q == 2'd2) ? `FCSD_UNL1_DATA :
                        (pre_q == 2'd1) ? `FCSD_UNL2_DATA : data_q;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else begin
      dq_s1_q <= fl_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      addr_q   <= {AW{1'b0}};
      data_q   <= 8'h00;
      rd_q     <= 1'b0;
      pre_q    <= 2'd0;
      busy_q   <= 1'b0;
      acc_q    <= 1'b0;
      st_q     <= S_IDLE;
      cnt_q    <= 8'h00;
      rdata_q  <= 8'h00;
      ncyc_q   <= 4'h0;
      fl_addr  <= {AW{1'b0}};
      fl_dq_o  <= 8'h00;
      fl_dq_oe <= 1'b0;
      fl_ce_n  <= 1'b1;
      fl_we_n  <= 1'b1;
      fl_oe_n  <= 1'b1;
      fl_acc   <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      fl_acc   <= acc_q;
      if (wb_req) begin
        case (wb_adr_i)
          `FCSD_REG_ADDR:   wb_dat_o <= {{(32-AW){1'b0}}, addr_q};
          `FCSD_REG_DATA:   wb_dat_o <= {24'h0, data_q};
          `FCSD_REG_RDATA:  wb_dat_o <= {24'h0, rdata_q};
          `FCSD_REG_STATUS: wb_dat_o <= {27'h0, ncyc_q, busy_q};
          `FCSD_REG_CTRL:   wb_dat_o <= {29'h0, acc_q, 1'b0, rd_q};
          default:          wb_dat_o <= 32'h0000_0000;
        endcase
      end
      if (wr_ok && !busy_q) begin
        case (wb_adr_i)
          `FCSD_REG_ADDR: addr_q <= wb_dat_i[AW-1:0];
          `FCSD_REG_DATA: data_q <= wb_dat_i[7:0];
          `FCSD_REG_CTRL: begin
            rd_q  <= wb_dat_i[`FCSD_CTRL_RD];
            acc_q <= wb_dat_i[`FCSD_CTRL_ACC];
            if (wb_dat_i[`FCSD_CTRL_GO]) begin
              // every go issues one complete bus cycle, three with the unlock prefix
              busy_q <= 1'b1;
              ncyc_q <= 4'h0;
              // unlock prefix only on writes
              pre_q  <= (wb_dat_i[`FCSD_CTRL_UNL] && !wb_dat_i[`FCSD_CTRL_RD]) ? 2'd2 : 2'd0;
            end
          end
          default: ;
        endcase
      end
      case (st_q)
        S_IDLE: begin
          if (busy_q) begin
            fl_addr  <= cur_a;
            fl_dq_o  <= cur_d;
            fl_dq_oe <= ~rd_q | (pre_q != 2'd0);
            fl_ce_n  <= 1'b0;
            st_q     <= S_SU;
            cnt_q    <= T_SU;
          end
        end
        S_SU: begin
          if (cnt_q == 8'h01) begin
            // address latched on falling strobe after setup
            if (rd_q && pre_q == 2'd0)
              fl_oe_n <= 1'b0;
            else
              fl_we_n <= 1'b0;
            st_q  <= S_PW;
            cnt_q <= T_PW;
          end else
            cnt_q <= cnt_q - 8'h01;
        end
        S_PW: begin
          if (cnt_q == 8'h01) begin
            if (!fl_oe_n)
              rdata_q <= dq_s2_q;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            st_q    <= S_HD;
            cnt_q   <= T_HD;
          end else
            cnt_q <= cnt_q - 8'h01;
        end
        S_HD: begin
          if (cnt_q == 8'h01) begin
            fl_ce_n  <= 1'b1;
            fl_dq_oe <= 1'b0;
            ncyc_q   <= ncyc_q + 4'h1;
            st_q     <= S_IDLE;
            if (pre_q != 2'd0)
              pre_q <= pre_q - 2'd1;
            else
              busy_q <= 1'b0;
          end else
            cnt_q <= cnt_q - 8'h01;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule // fcsd_host

/* dv/fcsd_assertions.sv */
// Purpose: port checks for fcsd_host
// Assumes: classic wishbone master
// Notes: strobe widths as handed over
`timescale 1ns/1ps
module fcsd_chk (
  input wire mclk,
  input wire arst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire fl_dq_oe,
  input wire fl_ce_n,
  input wire fl_we_n,
  input wire fl_oe_n,
  input wire fl_acc
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
  ack_answers_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  strobe_in_ce_a: assert property (!fl_we_n || !fl_oe_n |-> !fl_ce_n) else $error("ce high");
  strobe_excl_a: assert property (fl_we_n || fl_oe_n) else $error("we and oe");
  ce_setup_a: assert property ($fell(fl_ce_n) |-> (fl_we_n && fl_oe_n)[*4]) else $error("setup");
  we_width_a: assert property ($fell(fl_we_n) |-> (!fl_we_n)[*8] ##1 fl_we_n) else $error("we width");
  oe_width_a: assert property ($fell(fl_oe_n) |-> (!fl_oe_n)[*8] ##1 fl_oe_n) else $error("oe width");
  dq_drive_a: assert property (!fl_we_n |-> fl_dq_oe) else $error("dq idle");
  dq_release_a: assert property (!fl_oe_n |-> !fl_dq_oe) else $error("dq fight");
  cover property ($fell(fl_we_n));
  cover property ($fell(fl_oe_n));
  cover property ($rose(fl_acc));
endmodule // fcsd_chk

/* dv/fcsd_flash.sv */
// Purpose: flash device model at the pins
// Assumes: byte mode, id mode only
// Notes: dq shows inverse when idle
`timescale 1ns/1ps
module fcsd_flash (
  input  wire [21:0] a,
  input  wire [7:0]  d,
  input  wire        ce_n,
  input  wire        we_n,
  input  wire        oe_n,
  output reg  [7:0]  q
);
  reg [1:0] step = 2'h0;
  reg       id   = 1'b0;
  initial q = 8'h00;
  always @(posedge we_n) if (!ce_n) begin
    if (d == 8'hf0) id <= 1'b0;
    else if (step == 2'h2 && d == 8'h90) id <= 1'b1;
    step <= (a[11:0] == 12'haaa && d == 8'haa) ? 2'h1 : (step == 2'h1 && a[11:0] == 12'h555 && d == 8'h55) ? 2'h2 : 2'h0;
  end
  always @(oe_n) q <= oe_n ? ~q : id ? {7'h0, a[7:0] == 8'h04} : a[7:0] ^ 8'h5a;
endmodule // fcsd_flash

/* dv/tb_fcsd_host.sv */
// Purpose: sequence tests for fcsd_host
// Assumes: flash model answers reads
// Notes: one flash cycle per go, three with unlock prefix
`timescale 1ns/1ps
module tb_fcsd_host;
  logic mclk = 0, arst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 0, wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 0, r;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_acc;
  wire [21:0] fl_addr;
  wire [7:0] fl_dq_o, fl_dq_i;
  integer n_errors = 0, samples_checked = 0;
  fcsd_host u_dut (.*);
  fcsd_flash u_fl (.a(fl_addr), .d(fl_dq_o), .ce_n(fl_ce_n), .we_n(fl_we_n), .oe_n(fl_oe_n), .q(fl_dq_i));
  initial forever #2.5 mclk = ~mclk;
  task give_verdict;
    begin
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task wb(input [3:0] a, input [31:0] d, input w);
    integer n;
    begin
      n = 0;
      @(posedge mclk);
      wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
      @(posedge mclk);
      while (wb_ack_o !== 1'b1 && n < 100) begin n = n + 1; @(posedge mclk); end
      if (n == 100) n_errors = n_errors + 1;
      r = wb_dat_o;
      wb_cyc_i <= 0; wb_stb_i <= 0;
    end
  endtask
  task chk(input [31:0] e, input [31:0] s);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin n_errors = n_errors + 1; $display("BAD value exp %h got %h", e, s); end
    end
  endtask
  task fc(input [21:0] a, input [7:0] d, input [4:0] c);
    begin
      wb(1, a, 1); wb(2, d, 1); wb(0, c, 1);
      r = 1;
      while (r[0] === 1'b1) wb(4, 0, 0);
    end
  endtask
  task rd(input [21:0] a, input [7:0] e);
    begin fc(a, 0, 5'h03); wb(3, 0, 0); chk(e, r); end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1;
    wb(4, 0, 0); chk(0, r[0]);
    wb(7, 32'h5, 1); wb(7, 0, 0); chk(0, r);
    rd(22'h000012, 8'h48);
    fc(22'h000aaa, 8'h90, 5'h09);
    wb(4, 0, 0); chk(32'h6, r);
    wb(1, 0, 0); chk(32'haaa, r);
    rd(22'h010004, 8'h01);
    rd(22'h000008, 8'h00);
    fc(22'h000123, 8'hf0, 5'h01);
    rd(22'h010004, 8'h5e);
    fc(22'h000aaa, 8'haa, 5'h01); fc(22'h000555, 8'h55, 5'h01); fc(22'h000aaa, 8'h90, 5'h01);
    rd(22'h000004, 8'h01);
    fc(22'h000000, 8'hf0, 5'h01); fc(22'h000aaa, 8'haa, 5'h01); fc(22'h000123, 8'h55, 5'h01);
    fc(22'h000aaa, 8'h90, 5'h01); rd(22'h000004, 8'h5e);
    wb(0, 32'h4, 1); @(negedge mclk); chk(1, fl_acc);
    wb(0, 0, 1); @(negedge mclk); chk(0, fl_acc);
    give_verdict;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    n_errors = n_errors + 1;
    give_verdict;
  end
endmodule // tb_fcsd_host
bind fcsd_host fcsd_chk u_chk (.mclk(mclk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_acc(fl_acc));
